/* File: hopping_host_ctl.v */
// Host controller driving the decoder clock line and two-way data line
//
// Implementation choices: the register addresses and the address-and-strobe port.
`include "hopctl_regs.vh"
//
// Function
// - Host raises clock up to 500 ms; device answers by raising data. (This host gives up after T_RESP_MS, 170 ms.)
// - Host lowers clock after acknowledge; device drops then releases data.
// - Sender changes data on clock rise; receiver samples on clock fall.
// - Clock rising later than 50 us makes device drop data, then stream follows.
// - Command bytes: F0 read, E1 write, D2 learn, C3 erase, B4 program.
// - Read sends address truncated to seven bits, then one dummy byte.
// - Sequential read must clock again within 1 ms; address wraps at 128.
// - Write sends address and data LSB first, clock high commits; ack high.
// - Further write bytes are clocked in and committed by clock high again.
// - Erase sends command plus two bytes, clock high triggers; ack high.
// - Learn sends command and two dummy bytes; device acks with data high.
// - First learn transmission raises data 60 ms; at most eight zero bits.
// - Host keeps clock low 60 ms after first learn pulse falls.
module hopping_host_ctl #(
  parameter HALF_CYC  = (`T_HALF_NS + `MCLK_NS - 1) / `MCLK_NS,
  parameter GUARD_CYC = (`T_GUARD_US * 1000 + `MCLK_NS - 1) / `MCLK_NS + 1,
  parameter RESP_CYC  = (`T_RESP_MS * 1000000) / `MCLK_NS,
  parameter SEQ_CYC   = (`T_SEQ_MS * 1000000) / `MCLK_NS,
  parameter HOLD_CYC  = (`T_HOLD_MS * 1000000 + `MCLK_NS - 1) / `MCLK_NS
) (
  input  wire        mclk,     // System clock, 250 MHz
  input  wire        rst,      // Synchronous reset, active high
  input  wire [7:0]  addr,     // Register byte address
  input  wire [31:0] wdata,    // Register write data
  input  wire        wr,       // Write strobe
  input  wire        rd,       // Read strobe
  output reg  [31:0] rdata,    // Read data, cycle after rd
  output reg         sclk,     // Clock line to decoder
  input  wire        sdat_in,  // Data line level
  output reg         sdat_out, // Data line drive value
  output reg         sdat_oe   // Data line drive enable
);
  localparam [3:0] ST_IDLE = 4'h0, ST_REQ_HI = 4'h1, ST_REQ_LO = 4'h2, ST_TX = 4'h3;
  localparam [3:0] ST_RX = 4'h4, ST_COMMIT = 4'h5, ST_CMT_LO = 4'h6, ST_SEQ = 4'h7;
  localparam [3:0] ST_N_GUARD = 4'h8, ST_N_ACK = 4'h9, ST_L_ACK = 4'ha, ST_L_W0 = 4'hb;
  localparam [3:0] ST_L_W1 = 4'hc, ST_L_W1F = 4'hd, ST_L_HOLD = 4'he;
  localparam [1:0] RK_READ = 2'h0, RK_NOTIFY = 2'h1, RK_LEARN = 2'h2;

  reg  [3:0]  state;
  reg  [31:0] cnt;
  reg  [31:0] div;
  reg         tick;
  reg  [6:0]  bitn;
  reg  [6:0]  rx_target;
  reg  [1:0]  rx_kind;
  reg  [3:0]  byte_idx;
  reg  [3:0]  tx_len;
  reg  [2:0]  op;
  reg         seqw;
  reg  [7:0]  arg;
  reg  [7:0]  wd;
  reg  [7:0]  rbyte;
  reg  [79:0] rxsh;
  reg  [79:0] strm;
  reg  [15:0] lstat;
  reg         done;
  reg         ok;
  reg         tmo_err;
  reg         notify_rdy;
  reg         learn_rdy;
  reg         refused;
  reg         learning;
  reg         session;
  reg  [7:0]  txb;
  reg  [31:0] rmux;
  reg  [7:0]  prog [0:8];
  wire        dat_s;
  wire [79:0] next_sh;
  wire [2:0]  op_new;
  wire        nxt;
  wire        start;
  wire        cancel;
  wire [5:0]  clr;
  wire [7:0]  poff;
  wire        p_hit;

  // ==========================================================
  // Input synchroniser and decode
  hopctl_sync u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (sdat_in),
    .dout (dat_s)
  );

  // Software order decode
  assign op_new  = wdata[2:0];
  assign nxt     = wdata[`CTRL_NEXT];
  assign start   = wr && (addr == `A_CTRL) && (op_new >= `OP_READ) && (op_new <= `OP_PROG);
  assign cancel  = wr && (addr == `A_CTRL) && (op_new == `OP_CANCEL);
  assign clr     = (wr && (addr == `A_STATUS)) ? wdata[6:1] : 6'h00;
  assign next_sh = {dat_s, rxsh[79:1]}; // LSB arrives first
  assign poff    = addr - `A_PROG;
  assign p_hit   = (addr >= `A_PROG) && (addr <= `A_PROG_LAST) && (addr[1:0] == 2'b00);

  // ==========================================================
  // Bit-rate divider, one-cycle tick per half clock period
  always @(posedge mclk) begin
    if (rst) begin
      div  <= 32'h0;
      tick <= 1'b0;
    end else if (div >= HALF_CYC - 1) begin
      div  <= 32'h0;
      tick <= 1'b1;
    end else begin
      div  <= div + 32'h1;
      tick <= 1'b0;
    end
  end

  // ==========================================================
  // Outgoing byte selection
  always @* begin
    txb = 8'h00;
    if (seqw) begin
      txb = wd;
    end else if (byte_idx == 4'h0) begin
      case (op)
        `OP_READ:  txb = `CMD_READ;
        `OP_WRITE: txb = `CMD_WRITE;
        `OP_LEARN: txb = `CMD_LEARN;
        `OP_ERASE: txb = `CMD_ERASE;
        `OP_PROG:  txb = `CMD_PROG;
        default:   txb = 8'h00;
      endcase
    end else begin
      case (op)
        `OP_READ:  txb = (byte_idx == 4'h1) ? (arg & `ADDR_MASK) : 8'h00;
        `OP_WRITE: txb = (byte_idx == 4'h1) ? (arg & `ADDR_MASK) : wd;
        `OP_ERASE: txb = (byte_idx == 4'h1) ? arg : 8'h00;
        `OP_PROG:  txb = prog[byte_idx - 4'h1];
        default:   txb = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Plain registers written by software
  always @(posedge mclk) begin
    if (rst) begin
      arg <= 8'h00;
      wd  <= 8'h00;
    end else if (wr) begin
      if (addr == `A_ARG)
        arg <= wdata[7:0];
      if (addr == `A_WDATA)
        wd <= wdata[7:0];
    end
  end

  // Program payload bytes: configuration then manufacturer code
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_prog
      always @(posedge mclk) begin
        if (rst)
          prog[g] <= 8'h00;
        else if (wr && (addr == `A_PROG + 4 * g))
          prog[g] <= wdata[7:0];
      end
    end
  endgenerate

  // ==========================================================
  // Failure path: clock low, flag timeout, back to idle
  task fail;
    begin
      tmo_err <= 1'b1;
      done    <= 1'b1;
      sclk    <= 1'b0;
      session <= 1'b0;
      state   <= ST_IDLE;
    end
  endtask

  // ==========================================================
  // Link sequencer
  always @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE; cnt <= 32'h0; sclk <= 1'b0;
      sdat_out <= 1'b0; sdat_oe <= 1'b0;
      bitn <= 7'h0; rx_target <= 7'h0; rx_kind <= RK_READ;
      byte_idx <= 4'h0; tx_len <= 4'h0; op <= 3'h0; seqw <= 1'b0;
      rbyte <= 8'h00; rxsh <= 80'h0; strm <= 80'h0; lstat <= 16'h0;
      done <= 1'b0; ok <= 1'b0; tmo_err <= 1'b0; notify_rdy <= 1'b0;
      learn_rdy <= 1'b0; refused <= 1'b0; learning <= 1'b0; session <= 1'b0;
    end else begin
      // Software clears first so a same-cycle set wins
      done       <= done & ~clr[0];
      ok         <= ok & ~clr[1];
      tmo_err    <= tmo_err & ~clr[2];
      notify_rdy <= notify_rdy & ~clr[3];
      learn_rdy  <= learn_rdy & ~clr[4];
      refused    <= refused & ~clr[5];
      cnt        <= cnt + 32'h1;
      // Release data half a period after the last sent bit
      if (tick && (state != ST_TX))
        sdat_oe <= 1'b0;
      if (cancel) begin
        state    <= ST_IDLE;
        sclk     <= 1'b0;
        learning <= 1'b0;
        session  <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sclk <= 1'b0;
            cnt  <= 32'h0;
            if (dat_s) begin
              if (start)
                refused <= 1'b1;
              state <= ST_N_GUARD;
            end else if (start) begin
              if (nxt) begin
                refused <= 1'b1;
              end else begin
                op       <= op_new;
                seqw     <= 1'b0;
                byte_idx <= 4'h0;
                bitn     <= 7'h0;
                tx_len   <= (op_new == `OP_PROG) ? 4'ha : 4'h3;
                ok       <= 1'b0;
                sclk     <= 1'b1;
                state    <= ST_REQ_HI;
              end
            end
          end
          ST_REQ_HI: begin
            if (dat_s) begin
              if (tick && (cnt >= HALF_CYC - 1)) begin // Full high phase
                sclk  <= 1'b0;
                cnt   <= 32'h0;
                state <= ST_REQ_LO;
              end
            end else if (cnt >= RESP_CYC) begin
              fail;
            end
          end
          ST_REQ_LO: begin
            if (!dat_s) begin
              state <= ST_TX;
            end else if (cnt >= RESP_CYC) begin
              fail;
            end
          end
          ST_TX: begin
            if (tick) begin
              if (!sclk) begin
                sclk     <= 1'b1;
                sdat_oe  <= 1'b1;
                sdat_out <= txb[bitn[2:0]];
              end else begin
                sclk <= 1'b0;
                bitn <= bitn + 7'h1;
                if (bitn[2:0] == 3'h7) begin
                  if (byte_idx == tx_len - 4'h1) begin
                    bitn <= 7'h0;
                    cnt  <= 32'h0;
                    if (op == `OP_READ) begin
                      rx_kind   <= RK_READ;
                      rx_target <= `BYTE_BITS;
                      state     <= ST_RX;
                    end else if (op == `OP_LEARN) begin
                      state <= ST_L_ACK;
                    end else begin
                      state <= ST_COMMIT;
                    end
                  end else begin
                    byte_idx <= byte_idx + 4'h1;
                  end
                end
              end
            end
          end
          ST_RX: begin
            if (tick) begin
              if (!sclk) begin
                sclk <= 1'b1;
              end else begin
                sclk <= 1'b0;
                rxsh <= next_sh;
                bitn <= bitn + 7'h1;
                cnt  <= 32'h0;
                if (bitn == rx_target - 7'h1) begin
                  bitn <= 7'h0;
                  if (rx_kind == RK_NOTIFY) begin
                    strm       <= next_sh;
                    notify_rdy <= 1'b1;
                    state      <= ST_IDLE;
                  end else if (rx_kind == RK_LEARN) begin
                    lstat     <= next_sh[79:64];
                    learn_rdy <= 1'b1;
                    learning  <= 1'b0;
                    state     <= ST_IDLE;
                  end else begin
                    rbyte   <= next_sh[79:72];
                    ok      <= 1'b1;
                    done    <= 1'b1;
                    session <= 1'b1;
                    state   <= ST_SEQ;
                  end
                end
              end
            end
          end
          ST_COMMIT: begin
            if (!sclk) begin
              cnt <= 32'h0;
              if (tick)
                sclk <= 1'b1;
            end else if (dat_s) begin
              ok    <= 1'b1;
              state <= ST_CMT_LO;
            end else if (cnt >= RESP_CYC) begin
              fail;
            end
          end
          ST_CMT_LO: begin
            if (tick) begin
              sclk <= 1'b0;
              done <= 1'b1;
              cnt  <= 32'h0;
              if (op == `OP_WRITE) begin
                session <= 1'b1;
                state   <= ST_SEQ;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_SEQ: begin
            // Next byte must start well inside the device idle limit
            if (cnt >= SEQ_CYC - 2 * HALF_CYC) begin
              session <= 1'b0;
              state   <= ST_IDLE;
            end else if (start) begin
              if (nxt && (op_new == op) && (op == `OP_READ)) begin
                ok        <= 1'b0;
                rx_kind   <= RK_READ;
                rx_target <= `BYTE_BITS;
                bitn      <= 7'h0;
                state     <= ST_RX;
              end else if (nxt && (op_new == op) && (op == `OP_WRITE)) begin
                ok       <= 1'b0;
                seqw     <= 1'b1;
                byte_idx <= 4'h0;
                tx_len   <= 4'h1;
                bitn     <= 7'h0;
                state    <= ST_TX;
              end else begin
                refused <= 1'b1;
              end
            end
          end
          ST_N_GUARD: begin
            if (!dat_s) begin
              state <= ST_IDLE;
            end else if (cnt >= GUARD_CYC) begin
              sclk  <= 1'b1;
              cnt   <= 32'h0;
              state <= ST_N_ACK;
            end
          end
          ST_N_ACK: begin
            if (!dat_s) begin
              if (tick && (cnt >= HALF_CYC - 1)) begin // Full high phase
                sclk      <= 1'b0;
                bitn      <= 7'h0;
                rx_kind   <= learning ? RK_LEARN : RK_NOTIFY;
                rx_target <= learning ? `LEARN_BITS : `STREAM_BITS;
                state     <= ST_RX;
              end
            end else if (cnt >= RESP_CYC) begin
              fail;
            end
          end
          ST_L_ACK: begin
            if (dat_s) begin
              learning <= 1'b1;
              ok       <= 1'b1;
              done     <= 1'b1;
              state    <= ST_L_W0;
            end else if (cnt >= RESP_CYC) begin
              fail;
            end
          end
          ST_L_W0: begin
            if (!dat_s)
              state <= ST_L_W1;
          end
          ST_L_W1: begin
            if (dat_s)
              state <= ST_L_W1F;
          end
          ST_L_W1F: begin
            cnt <= 32'h0;
            if (!dat_s)
              state <= ST_L_HOLD;
          end
          ST_L_HOLD: begin
            sclk <= 1'b0;
            if (cnt >= HOLD_CYC)
              state <= ST_IDLE;
          end
          default: begin
            sclk  <= 1'b0;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register read path, data valid only in the cycle after rd
  always @* begin
    rmux = 32'h0;
    case (addr)
      `A_ARG:    rmux = {24'h0, arg};
      `A_WDATA:  rmux = {24'h0, wd};
      `A_STATUS: rmux = {22'h0, dat_s, session, learning, refused, learn_rdy,
                         notify_rdy, tmo_err, ok, done, (state != ST_IDLE)};
      `A_RDATA:  rmux = {24'h0, rbyte};
      `A_STRM0:  rmux = strm[31:0];
      `A_STRM1:  rmux = strm[63:32];
      `A_STRM2:  rmux = {16'h0, strm[79:64]};
      `A_LSTAT:  rmux = {16'h0, lstat};
      default: begin
        if (p_hit)
          rmux = {24'h0, prog[poff[5:2]]};
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst)
      rdata <= 32'h0;
    else if (rd)
      rdata <= rmux;
    else
      rdata <= 32'h0;
  end
endmodule // hopping_host_ctl

/* File: hopctl_regs.vh */
// Register map, command codes and timing constants of the hopping decoder host port
`ifndef HOPCTL_REGS_VH
`define HOPCTL_REGS_VH
// ==========================================================
// Register offsets (byte addresses)
`define A_CTRL      8'h00
`define A_ARG       8'h04
`define A_WDATA     8'h08
`define A_STATUS    8'h0c
`define A_RDATA     8'h10
`define A_STRM0     8'h14
`define A_STRM1     8'h18
`define A_STRM2     8'h1c
`define A_PROG      8'h20
`define A_PROG_LAST 8'h40
`define A_LSTAT     8'h44
// ==========================================================
// Control fields and operation codes
`define CTRL_NEXT   3
`define OP_READ     3'h1
`define OP_WRITE    3'h2
`define OP_LEARN    3'h3
`define OP_ERASE    3'h4
`define OP_PROG     3'h5
`define OP_CANCEL   3'h7
// ==========================================================
// Status bit positions
`define S_BUSY      0
`define S_DONE      1
`define S_OK        2
`define S_TMO       3
`define S_NOTIFY    4
`define S_LEARN     5
`define S_REFUSED   6
`define S_LEARNING  7
`define S_SESSION   8
`define S_DATA      9
// ==========================================================
// Command bytes and address mask
`define CMD_READ    8'hf0
`define CMD_WRITE   8'he1
`define CMD_LEARN   8'hd2
`define CMD_ERASE   8'hc3
`define CMD_PROG    8'hb4
`define ADDR_MASK   8'h7f
// ==========================================================
// Timing and stream lengths
`define MCLK_NS     4
`define T_HALF_NS   1000
`define T_GUARD_US  50
`define T_RESP_MS   170
`define T_SEQ_MS    1
`define T_HOLD_MS   60
`define STREAM_BITS 7'd80
`define LEARN_BITS  7'd16
`define BYTE_BITS   7'd8
`endif

/* File: hopctl_sync.v */
// Two flip-flop synchroniser for the decoder data pin
module hopctl_sync (
  input  wire mclk, // System clock
  input  wire rst,  // Synchronous reset
  input  wire din,  // Asynchronous pin level
  output wire dout  // Synchronised level
);
  reg meta;
  reg stab;
  // ==========================================================
  // Synchroniser stages
  always @(posedge mclk) begin
    if (rst) begin
      meta <= 1'b0;
      stab <= 1'b0;
    end else begin
      meta <= din;
      stab <= meta;
    end
  end
  assign dout = stab;
endmodule // hopctl_sync

/* File: hopping_host_ctl_properties.sv */
// Bus and link timing checks for the host controller
module hopctl_checker #(
  parameter HALF_CYC = 250,
  parameter RESP_CYC = 42500000
) (
  input wire        mclk,     // Clock
  input wire        rst,      // Reset
  input wire [7:0]  addr,     // Address
  input wire [31:0] wdata,    // Write data
  input wire        wr,       // Write strobe
  input wire        rd,       // Read strobe
  input wire [31:0] rdata,    // Read data
  input wire        sclk,     // Link clock
  input wire        sdat_in,  // Line level
  input wire        sdat_out, // Drive value
  input wire        sdat_oe   // Drive enable
);
  reg [31:0] ph; // Samples at current level
  reg [31:0] hi; // Samples with clock high
  reg        lv; // Previous sampled level
  // Level run counters
  always @(posedge mclk) begin
    if (rst) begin
      ph <= 32'h0;
      hi <= 32'h0;
      lv <= 1'b0;
    end else begin
      lv <= sclk;
      ph <= (sclk != lv) ? 32'h1 : ph + 32'h1;
      hi <= sclk ? hi + 32'h1 : 32'h0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  reset_idle_a: assert property (disable iff (1'b0) $past(rst) |-> !sclk && !sdat_oe)
    else $error("link not idle after reset");
  rdata_quiet_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  phase_min_a: assert property (sclk != lv |-> ph >= HALF_CYC)
    else $error("clock phase too short");
  clk_high_max_a: assert property (hi <= RESP_CYC + 2 * HALF_CYC)
    else $error("clock held high too long");
  data_rise_edge_a: assert property (sdat_oe && $past(sdat_oe) && $changed(sdat_out) |-> $rose(sclk))
    else $error("data changed off rising clock");
  data_hold_fall_a: assert property ($fell(sclk) && sdat_oe |-> $stable(sdat_out))
    else $error("data moved at falling clock");
  oe_start_rise_a: assert property ($rose(sdat_oe) |-> $rose(sclk))
    else $error("drive began off rising clock");
  oe_stop_low_a: assert property ($fell(sdat_oe) |-> !$past(sclk))
    else $error("drive released during high phase");
  c_drive: cover property ($rose(sdat_oe));
  c_ack: cover property (sclk && sdat_in && !sdat_oe);
  c_read: cover property (rd ##1 rdata != 32'h0);
endmodule // hopctl_checker
bind hopping_host_ctl hopctl_checker #(.HALF_CYC(HALF_CYC), .RESP_CYC(RESP_CYC)) u_chk (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sclk(sclk), .sdat_in(sdat_in), .sdat_out(sdat_out), .sdat_oe(sdat_oe));

/* File: hopctl_decoder_model.sv */
// Behavioural decoder on the far side of the link
module hopctl_decoder_model (
  input  wire logic sclk,     // Link clock from host
  input  wire logic mclk,     // Bench clock
  input  wire logic sdat_out, // Host drive value
  input  wire logic sdat_oe,  // Host drive enable
  output wire logic line      // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        dev_oe = 1'b1;  // Device drives line
  logic        dev_out = 1'b0; // Device drive value
  logic        last = 1'b0;    // Line last cycle
  logic        note = 1'b0;    // Notification request
  logic [7:0]  mem [0:127];    // User memory
  logic [23:0] rx;             // Received bytes
  logic [79:0] strm;           // Notification payload
  logic [6:0]  a;              // Memory pointer
  integer      i;              // Bit index
  // Released line toggles so a stale level never passes
  assign line = sdat_oe ? sdat_out : (dev_oe ? dev_out : ~last);
  always @(posedge mclk) last <= line;
  // ==========================================================
  // Device sequencer
  initial begin
    for (i = 0; i < 128; i++) mem[i] = i[7:0] * 8'h03 ^ 8'ha5;
    forever begin
      dev_oe = 1'b1;
      dev_out = 1'b0;
      wait (sclk || note);
      if (note && !sclk) begin
        dev_out = 1'b1;
        @(posedge sclk);
        #2 dev_out = 1'b0;
        for (i = 0; i < 80; i++) begin
          @(posedge sclk);
          #2 dev_out = strm[i];
        end
        @(negedge sclk);
        note = 1'b0;
      end else begin
        #2 dev_out = 1'b1;
        @(negedge sclk);
        #2 dev_out = 1'b0;
        #8 dev_oe = 1'b0;
        for (i = 0; i < 24; i++) begin
          @(negedge sclk);
          rx[i] = line;
        end
        a = rx[14:8];
        if (rx[7:0] == 8'hf0) begin
          for (i = 0; i < 8; i++) begin
            @(posedge sclk);
            #2 dev_oe = 1'b1;
            dev_out = mem[a][i];
          end
          @(negedge sclk);
        end else if (rx[7:0] == 8'he1 || rx[7:0] == 8'hc3) begin
          @(posedge sclk);
          if (rx[7:0] == 8'he1) mem[a] = rx[23:16];
          #2 dev_oe = 1'b1;
          dev_out = 1'b1;
          @(negedge sclk);
        end else if (rx[7:0] == 8'hd2) begin
          #18 dev_oe = 1'b1;
          dev_out = 1'b1;
          #40 dev_out = 1'b0;
          #40 dev_out = 1'b1;
          #80 dev_out = 1'b0;
          #2400 note = 1'b1;
        end
      end
    end
  end
endmodule // hopctl_decoder_model

/* File: hopping_host_ctl_tb.sv */
// Self-checking bench for the host controller
module hopping_host_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;               // System clock
  logic        rst;                // Reset
  logic [7:0]  addr;               // Register address
  logic [31:0] wdata;              // Write data
  logic        wr;                 // Write strobe
  logic        rd;                 // Read strobe
  logic        chk;                // Read is checked
  wire  [31:0] rdata;              // Read data
  wire         sclk;               // Link clock
  wire         sdat_out;           // Host drive value
  wire         sdat_oe;            // Host drive enable
  wire         line;               // Resolved data line
  logic        rd_q = 1'b0;        // Read last cycle
  logic        chk_q = 1'b0;       // Checked read last cycle
  logic [31:0] seen;               // Last read result
  logic [39:0] expq [$];           // Expected address and data
  logic [39:0] e;                  // Oldest note
  logic [79:0] s;                  // Stream payload
  logic [7:0]  a;                  // Address
  logic [7:0]  d;                  // Data
  integer      errors = 0;         // Mismatches
  integer      checked = 0;        // Comparisons
  integer      seed = 32'h3466077d; // Random seed
  integer      k;                  // Loop index
  hopping_host_ctl #(.HALF_CYC(4), .GUARD_CYC(20), .RESP_CYC(2000), .SEQ_CYC(2000),
    .HOLD_CYC(500)) DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sclk(sclk), .sdat_in(line), .sdat_out(sdat_out),
    .sdat_oe(sdat_oe));
  hopctl_decoder_model m (.sclk(sclk), .mclk(mclk), .sdat_out(sdat_out),
    .sdat_oe(sdat_oe), .line(line));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // Tasks
  task automatic cmp(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt,
                     input logic c);
    wr <= w;
    rd <= !w;
    chk <= c;
    addr <= ad;
    wdata <= dt;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] ex);
    expq.push_back({ad, ex});
    bus(1'b0, ad, 32'h0, 1'b1);
  endtask
  task automatic wait_bit(input integer b);
    integer j;
    for (j = 0; j < 4000; j++) begin
      bus(1'b0, 8'h0c, 32'h0, 1'b0);
      @(posedge mclk);
      if (seen[b] === 1'b1) break;
    end
    cmp($sformatf("status_%0d", b), {31'h0, seen[b]}, 32'h1);
  endtask
  // Start an operation, wait done, then let the session lapse
  task automatic run(input logic [2:0] op, input logic [7:0] arg);
    bus(1'b1, 8'h0c, 32'h7e, 1'b0);
    bus(1'b1, 8'h04, {24'h0, arg}, 1'b0);
    bus(1'b1, 8'h00, {29'h0, op}, 1'b0);
    wait_bit(1);
    cmp("done_ok", seen & 32'h4e, 32'h6);
    repeat (2100) @(posedge mclk);
  endtask
  function automatic logic [7:0] mexp(input logic [6:0] x);
    return {1'b0, x} * 8'h03 ^ 8'ha5;
  endfunction
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Result monitor takes the oldest note per checked read
  always @(posedge mclk) begin
    rd_q <= rd;
    chk_q <= chk && rd;
    if (rd_q) seen = rdata;
    if (chk_q) begin
      e = expq.pop_front();
      cmp($sformatf("rdata_%h", e[39:32]), rdata, e[31:0]);
    end
  end
  // Watchdog well past the expected run
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    chk = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    rchk(8'h0c, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h48, 32'h0);
    $display("reset test done");
    a = 8'($random(seed)) | 8'h80;
    run(3'h1, a);
    cmp("read_cmd", {8'h0, m.rx}, {17'h0, a[6:0], 8'hf0});
    rchk(8'h10, {24'h0, mexp(a[6:0])});
    $display("read test done");
    d = 8'($random(seed));
    bus(1'b1, 8'h08, {24'h0, d}, 1'b0);
    run(3'h2, a ^ 8'h15);
    cmp("write_cmd", {8'h0, m.rx}, {8'h0, d, 1'b0, a[6:0] ^ 7'h15, 8'he1});
    run(3'h1, a ^ 8'h15);
    rchk(8'h10, {24'h0, d});
    $display("write test done");
    for (k = 0; k < 2; k++) begin
      run(3'h4, k[7:0]);
      cmp("erase_cmd", {8'h0, m.rx}, {16'h0, k[7:0], 8'hc3});
    end
    $display("erase test done");
    s = {16'($random(seed)), 32'($random(seed)), 32'($random(seed))};
    m.strm = s;
    m.note = 1'b1;
    wait_bit(4);
    rchk(8'h14, s[31:0]);
    rchk(8'h18, s[63:32]);
    rchk(8'h1c, {16'h0, s[79:64]});
    $display("notify test done");
    s = {64'h0, 1'b0, 4'($random(seed)), 4'h3, 2'b01, 5'h00};
    m.strm = s;
    run(3'h3, 8'h00);
    cmp("learn_cmd", {8'h0, m.rx}, {24'h0, 8'hd2});
    wait_bit(5);
    rchk(8'h44, {16'h0, s[15:0]});
    $display("learn test done");
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule // hopping_host_ctl_tb
